// ---- core/scs_core.sv ----
// serial control and status registers with prescaler, flags and interrupt requests
// Functional notes
// - prescaler select gives clock undivided, /4, /16 or /64 to baud generator
// - transmit interrupt requested by empty flag and enable; ends on clear
// - receive full and error interrupts gated by receive interrupt enable bit
// - transmit starts after holding write and empty flag clear; format set first
// - transmit empty flag held at one while transmit disabled
// - reception begins on start bit or synchronous clock when enabled
// - clearing receive enable leaves receive status flags unchanged
// - address wait discards frames with address bit zero, no flags set
// - frame with address bit one sets flag and clears address wait
// - done interrupt requested by done flag and enable; clears with empty flag
// - asynchronous clock source: port, bit clock out, or external x16
// - synchronous clock source: internal clock out or external input
// - card mode without cellular option: pin port or clock out
// - cellular option: fixed low, fixed high or clock output
// - status flags clear by writing zero or, for empty and full, by dma; one writes ignored except to the transmit address bit, which takes the written value
// - empty flag sets when disabled or on load; clears by write or dma
// - full flag sets on good frame; clears by write or dma read
// - reception while full sets overrun and drops new data
// - stop bit zero sets framing flag and stops further reception
// - done flag sets when disabled or last bit sent while empty
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.svh"
module scs_core
  import scs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire scs_line_s  line_in,
  output scs_ctl_s        ctl_out
);
  scs_state_s s_q;
  scs_state_s s_d;
  logic       rx_ok;
  logic       rx_blocked;
  logic [5:0] pre_last;
  logic       ck_hi;
  logic       ck_lo;
  logic       sync_m;
  logic       gm;

  always_comb begin
    s_d        = s_q;
    ck_hi      = s_q.ctrl[`SCS_CTL_CK1];
    ck_lo      = s_q.ctrl[`SCS_CTL_CK0];
    sync_m     = s_q.mode[`SCS_MODE_SYNC];
    gm         = s_q.mode[`SCS_MODE_GM];
    rx_ok      = 1'b0;
    rx_blocked = 1'b0;
    pre_last   = 6'h00;
    case (s_q.mode[1:0])
      2'b01:   pre_last = `SCS_DIV4_LAST;
      2'b10:   pre_last = `SCS_DIV16_LAST;
      2'b11:   pre_last = `SCS_DIV64_LAST;
      default: pre_last = 6'h00;
    endcase
    if (s_q.pre >= pre_last) begin
      s_d.pre  = 6'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.pre  = s_q.pre + 6'h01;
      s_d.tick = 1'b0;
    end
    if (s_q.tick) begin
      s_d.sck_div = ~s_q.sck_div;
    end
    s_d.rdata = 8'h00;
    // register reads, remember flags seen as one
    if (reg_rd) begin
      if (reg_addr == `SCS_ADDR_MODE) begin
        s_d.rdata = s_q.mode;
      end else if (reg_addr == `SCS_ADDR_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (reg_addr == `SCS_ADDR_STAT) begin
        s_d.rdata    = s_q.stat;
        s_d.rd_tdre1 = s_q.stat[`SCS_ST_TX_EMPTY_FLAG];
        s_d.rd_rdrf1 = s_q.stat[`SCS_ST_RX_FULL_FLAG];
        s_d.rd_orer1 = s_q.stat[`SCS_ST_OVERRUN_FLAG];
        s_d.rd_fer1  = s_q.stat[`SCS_ST_FER];
        s_d.rd_per1  = s_q.stat[`SCS_ST_PER];
      end else if (reg_addr == `SCS_ADDR_TXD) begin
        s_d.rdata = s_q.txd;
      end else if (reg_addr == `SCS_ADDR_RXD) begin
        s_d.rdata = s_q.rxd;
      end else if (reg_addr == `SCS_ADDR_CARD) begin
        s_d.rdata = {7'h00, s_q.card};
      end else begin
        s_d.rdata = 8'h00;
      end
    end
    // register writes
    if (reg_wr) begin
      if (reg_addr == `SCS_ADDR_MODE) begin
        s_d.mode = reg_wdata;
      end else if (reg_addr == `SCS_ADDR_CTRL) begin
        s_d.ctrl = reg_wdata;
      end else if (reg_addr == `SCS_ADDR_STAT) begin
        if (!reg_wdata[`SCS_ST_TX_EMPTY_FLAG] && s_q.rd_tdre1) begin
          s_d.stat[`SCS_ST_TX_EMPTY_FLAG] = 1'b0;
          s_d.stat[`SCS_ST_TX_DONE_FLAG] = 1'b0;
          s_d.rd_tdre1           = 1'b0;
        end
        if (!reg_wdata[`SCS_ST_RX_FULL_FLAG] && s_q.rd_rdrf1) begin
          s_d.stat[`SCS_ST_RX_FULL_FLAG] = 1'b0;
          s_d.rd_rdrf1           = 1'b0;
        end
        if (!reg_wdata[`SCS_ST_OVERRUN_FLAG] && s_q.rd_orer1) begin
          s_d.stat[`SCS_ST_OVERRUN_FLAG] = 1'b0;
          s_d.rd_orer1           = 1'b0;
        end
        if (!reg_wdata[`SCS_ST_FER] && s_q.rd_fer1) begin
          s_d.stat[`SCS_ST_FER] = 1'b0;
          s_d.rd_fer1           = 1'b0;
        end
        if (!reg_wdata[`SCS_ST_PER] && s_q.rd_per1) begin
          s_d.stat[`SCS_ST_PER] = 1'b0;
          s_d.rd_per1           = 1'b0;
        end
        s_d.stat[`SCS_ST_ADDR_FLAG_TX] = reg_wdata[`SCS_ST_ADDR_FLAG_TX];
      end else if (reg_addr == `SCS_ADDR_TXD) begin
        s_d.txd = reg_wdata;
      end else if (reg_addr == `SCS_ADDR_CARD) begin
        s_d.card = reg_wdata[0];
      end
    end
    if (line_in.dma_tx_ack && s_q.out.tx_empty_irq) begin
      s_d.stat[`SCS_ST_TX_EMPTY_FLAG] = 1'b0;
      s_d.stat[`SCS_ST_TX_DONE_FLAG] = 1'b0;
    end
    if (line_in.dma_rx_ack && s_q.out.rx_full_irq) begin
      s_d.stat[`SCS_ST_RX_FULL_FLAG] = 1'b0;
    end
    s_d.out.tx_load = 1'b0;
    case (s_q.tx_st)
      SCS_TX_IDLE: begin
        if (s_q.ctrl[`SCS_CTL_TE] && !s_q.stat[`SCS_ST_TX_EMPTY_FLAG]) begin
          s_d.tx_st = SCS_TX_LOAD;
        end
      end
      SCS_TX_LOAD: begin
        s_d.out.tx_load = 1'b1;
        s_d.out.tx_byte = s_q.txd;
        s_d.out.tx_mpb  = s_q.stat[`SCS_ST_ADDR_FLAG_TX];
        // empty sets on load, set wins
        s_d.stat[`SCS_ST_TX_EMPTY_FLAG] = 1'b1;
        s_d.tx_st              = SCS_TX_BUSY;
      end
      SCS_TX_BUSY: begin
        if (line_in.tx_last_bit) begin
          // done on last bit when empty
          if (s_q.stat[`SCS_ST_TX_EMPTY_FLAG]) begin
            s_d.stat[`SCS_ST_TX_DONE_FLAG] = 1'b1;
            s_d.tx_st              = SCS_TX_IDLE;
          end else begin
            s_d.tx_st = SCS_TX_LOAD;
          end
        end
      end
      default: s_d.tx_st = SCS_TX_IDLE;
    endcase
    if (!s_q.ctrl[`SCS_CTL_TE]) begin
      s_d.stat[`SCS_ST_TX_EMPTY_FLAG] = 1'b1;
      s_d.stat[`SCS_ST_TX_DONE_FLAG] = 1'b1;
      s_d.tx_st              = SCS_TX_IDLE;
    end
    rx_blocked = s_q.stat[`SCS_ST_OVERRUN_FLAG] | s_q.stat[`SCS_ST_FER] | s_q.stat[`SCS_ST_PER];
    if (s_q.ctrl[`SCS_CTL_RE] && line_in.start_seen && !rx_blocked) begin
      s_d.rx_busy = 1'b1;
    end
    if (!s_q.ctrl[`SCS_CTL_RE]) begin
      s_d.rx_busy = 1'b0;
    end
    if (line_in.rx_done && s_q.rx_busy) begin
      s_d.rx_busy = 1'b0;
      rx_ok       = 1'b1;
      if (s_q.mode[`SCS_MODE_MP] && !sync_m) begin
        s_d.stat[`SCS_ST_MPB] = line_in.rx_mpb;
        if (s_q.ctrl[`SCS_CTL_ADDR_WAIT_EN] && !line_in.rx_mpb) begin
          rx_ok = 1'b0;
        end
        if (s_q.ctrl[`SCS_CTL_ADDR_WAIT_EN] && line_in.rx_mpb) begin
          s_d.ctrl[`SCS_CTL_ADDR_WAIT_EN] = 1'b0;
        end
      end
    end
    if (rx_ok) begin
      if (s_q.stat[`SCS_ST_RX_FULL_FLAG]) begin
        s_d.stat[`SCS_ST_OVERRUN_FLAG] = 1'b1;
      end else if (line_in.rx_frame_err && !sync_m) begin
        s_d.stat[`SCS_ST_FER] = 1'b1;
        s_d.rxd               = line_in.rx_data;
      end else if (line_in.rx_parity_err && !sync_m) begin
        s_d.stat[`SCS_ST_PER] = 1'b1;
        s_d.rxd               = line_in.rx_data;
      end else begin
        s_d.stat[`SCS_ST_RX_FULL_FLAG] = 1'b1;
        s_d.rxd                = line_in.rx_data;
      end
    end
    if (s_q.card && line_in.card_err) begin
      s_d.stat[`SCS_ST_FER] = 1'b1;
    end
    s_d.out.tx_empty_irq = s_d.stat[`SCS_ST_TX_EMPTY_FLAG] & s_d.ctrl[`SCS_CTL_TIE];
    s_d.out.rx_full_irq  = s_d.stat[`SCS_ST_RX_FULL_FLAG] & s_d.ctrl[`SCS_CTL_RIE];
    s_d.out.rx_err_irq   = (s_d.stat[`SCS_ST_OVERRUN_FLAG] | s_d.stat[`SCS_ST_FER] | s_d.stat[`SCS_ST_PER])
                           & s_d.ctrl[`SCS_CTL_RIE];
    s_d.out.tx_done_irq  = s_d.stat[`SCS_ST_TX_DONE_FLAG] & s_d.ctrl[`SCS_CTL_DONE_IRQ_EN];
    s_d.out.baud_tick    = s_q.tick;
    s_d.out.rx_run       = s_d.rx_busy;
    s_d.out.sck_o        = s_q.sck_div;
    s_d.out.sck_oe_n     = 1'b1;
    s_d.out.sck_ext      = 1'b0;
    if (s_q.card) begin
      if (gm) begin
        s_d.out.sck_oe_n = 1'b0;
        if (!ck_lo) begin
          s_d.out.sck_o = ck_hi;
        end
      end else begin
        s_d.out.sck_oe_n = !(ck_lo && !ck_hi);
      end
    end else if (sync_m) begin
      s_d.out.sck_oe_n = ck_hi;
      s_d.out.sck_ext  = ck_hi;
    end else begin
      s_d.out.sck_oe_n = ck_hi | !ck_lo;
      s_d.out.sck_ext  = ck_hi;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.mode     <= `SCS_MODE_RST;
      s_q.ctrl     <= `SCS_CTRL_RST;
      s_q.stat     <= `SCS_STAT_RST;
      s_q.tx_st    <= SCS_TX_IDLE;
      s_q.out.sck_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign ctl_out   = s_q.out;
endmodule
`default_nettype wire

// ---- core/scs_pkg.sv ----
// types of the serial control and status logic
package scs_pkg;
  typedef enum logic [2:0] {
    SCS_TX_IDLE = 3'h1,
    SCS_TX_LOAD = 3'h2,
    SCS_TX_BUSY = 3'h4
  } scs_tx_e;
  typedef struct packed {
    logic       rx_done;
    logic       rx_mpb;
    logic       rx_frame_err;
    logic       rx_parity_err;
    logic [7:0] rx_data;
    logic       start_seen;
    logic       card_err;
    logic       tx_last_bit;
    logic       dma_tx_ack;
    logic       dma_rx_ack;
  } scs_line_s;
  typedef struct packed {
    logic       tx_empty_irq;
    logic       rx_full_irq;
    logic       rx_err_irq;
    logic       tx_done_irq;
    logic       baud_tick;
    logic       tx_load;
    logic [7:0] tx_byte;
    logic       tx_mpb;
    logic       rx_run;
    logic       sck_o;
    logic       sck_oe_n;
    logic       sck_ext;
  } scs_ctl_s;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic       card;
    logic [7:0] rdata;
    logic [5:0] pre;
    logic       tick;
    logic       sck_div;
    scs_tx_e    tx_st;
    logic       rd_tdre1;
    logic       rd_rdrf1;
    logic       rd_orer1;
    logic       rd_fer1;
    logic       rd_per1;
    logic       rx_busy;
    scs_ctl_s   out;
  } scs_state_s;
endpackage

// ---- core/scs_regs.svh ----
// register offsets, field positions and reset values of the serial control and status logic
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
`define SCS_ADDR_MODE     3'h0
`define SCS_ADDR_CTRL     3'h1
`define SCS_ADDR_STAT     3'h2
`define SCS_ADDR_TXD      3'h3
`define SCS_ADDR_RXD      3'h4
`define SCS_ADDR_CARD     3'h5
`define SCS_MODE_SYNC     7
`define SCS_MODE_MP       2
`define SCS_MODE_GM       7
`define SCS_CTL_TIE       7
`define SCS_CTL_RIE       6
`define SCS_CTL_TE        5
`define SCS_CTL_RE        4
`define SCS_CTL_ADDR_WAIT_EN      3
`define SCS_CTL_DONE_IRQ_EN      2
`define SCS_CTL_CK1       1
`define SCS_CTL_CK0       0
`define SCS_ST_TX_EMPTY_FLAG       7
`define SCS_ST_RX_FULL_FLAG       6
`define SCS_ST_OVERRUN_FLAG       5
`define SCS_ST_FER        4
`define SCS_ST_PER        3
`define SCS_ST_TX_DONE_FLAG       2
`define SCS_ST_MPB        1
`define SCS_ST_ADDR_FLAG_TX       0
`define SCS_MODE_RST      8'h00
`define SCS_CTRL_RST      8'h00
`define SCS_STAT_RST      8'h84
`define SCS_DIV4_LAST     6'h03
`define SCS_DIV16_LAST    6'h0F
`define SCS_DIV64_LAST    6'h3F
`endif

// ---- verif/scs_core_sva.sv ----
// assertion checker for the serial control and status logic
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.svh"
module scs_core_sva
  import scs_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire scs_ctl_s   ctl_out
);
  logic [7:0] mode_q, ctrl_q, txd_q;
  logic       card_q;
  logic [1:0] chg_q;
  logic [5:0] gap_q, gap_e;
  logic [4:0] pin_e;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {mode_q, ctrl_q, txd_q, card_q} <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `SCS_ADDR_MODE: mode_q <= reg_wdata;
        `SCS_ADDR_CTRL: ctrl_q <= reg_wdata;
        `SCS_ADDR_TXD:  txd_q <= reg_wdata;
        `SCS_ADDR_CARD: card_q <= reg_wdata[0];
        default: ;
      endcase
    end
  end
  // gap judged only two ticks after a divider change
  always_ff @(posedge clk) begin
    gap_q <= (sys_rst || ctl_out.baud_tick) ? 6'h00 : gap_q + 6'h01;
    if (sys_rst || (reg_wr && reg_addr == `SCS_ADDR_MODE)) begin
      chg_q <= 2'h2;
    end else if (ctl_out.baud_tick && chg_q != 2'h0) begin
      chg_q <= chg_q - 2'h1;
    end
  end
  // pin_e: check, oe_n, ext, level check, level
  always_comb begin
    gap_e = 6'h3F >> (3'h6 - {mode_q[1:0], 1'b0});
    pin_e = 5'h00;
    if (!card_q) begin
      pin_e = ctrl_q[1] ? 5'h1C : ((ctrl_q[0] || mode_q[7]) ? 5'h10 : 5'h18);
    end else if (mode_q[7]) begin
      pin_e = {3'h4, !ctrl_q[0], ctrl_q[1]};
    end else if (!ctrl_q[1]) begin
      pin_e = ctrl_q[0] ? 5'h10 : 5'h18;
    end
  end
  a_baud_gap: assert property (ctl_out.baud_tick && chg_q == 2'h0 |-> gap_q == gap_e)
    else $error("prescaler gap wrong");
  a_txirq_gate: assert property (ctl_out.tx_empty_irq |-> ctrl_q[`SCS_CTL_TIE])
    else $error("tx empty request while disabled");
  a_rxirq_gate: assert property (ctl_out.rx_full_irq || ctl_out.rx_err_irq |-> ctrl_q[`SCS_CTL_RIE])
    else $error("rx request while disabled");
  a_done_gate: assert property (ctl_out.tx_done_irq |-> ctrl_q[`SCS_CTL_DONE_IRQ_EN])
    else $error("done request while disabled");
  a_off_empty: assert property ((!ctrl_q[5] && ctrl_q[7])[*3] |-> ctl_out.tx_empty_irq)
    else $error("empty not held with tx off");
  a_off_done: assert property ((!ctrl_q[5] && ctrl_q[2])[*3] |-> ctl_out.tx_done_irq)
    else $error("done not set with tx off");
  a_load_byte: assert property (ctl_out.tx_load |-> ctl_out.tx_byte == txd_q)
    else $error("loaded byte wrong");
  a_load_on: assert property ($rose(ctl_out.tx_load) |-> $past(ctrl_q[`SCS_CTL_TE], 2))
    else $error("load with tx off");
  a_pin_cfg: assert property (pin_e[4] && $stable(pin_e) |-> ctl_out.sck_oe_n == pin_e[3]
    && ctl_out.sck_ext == pin_e[2] && (!pin_e[1] || ctl_out.sck_o == pin_e[0]))
    else $error("clock pin setup wrong");
  c_load: cover property (ctl_out.tx_load);
  c_rx: cover property (ctl_out.rx_full_irq);
  c_err: cover property (ctl_out.rx_err_irq);
endmodule
`default_nettype wire

// ---- verif/scs_line_model.sv ----
// remote serial node model driving the line side
`timescale 1ns/100ps
`default_nettype none
module scs_line_model
  import scs_pkg::*;
(
  input  wire logic clk,
  output scs_line_s line_in
);
  initial line_in = '0;
  task automatic frame(input logic [7:0] d, input logic m, input logic fe, input logic pe);
    line_in <= '{start_seen: 1'b1, rx_data: ~d, default: '0};
    @(posedge clk) line_in <= '{rx_data: ~d, default: '0};
    repeat (3) @(posedge clk);
    line_in <= '{rx_done: 1'b1, rx_mpb: m, rx_frame_err: fe, rx_parity_err: pe, rx_data: d, default: '0};
    @(posedge clk) line_in <= '{rx_mpb: ~m, rx_data: ~d, default: '0};
    @(posedge clk);
  endtask
  task automatic strobe(input scs_line_s p);
    line_in <= p;
    @(posedge clk) line_in <= '0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking testbench for the serial control and status logic
`timescale 1ns/100ps
`default_nettype none
`include "scs_regs.svh"
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end
module tb_top
  import scs_pkg::*;
;
  localparam logic [2:0] md = `SCS_ADDR_MODE, ct = `SCS_ADDR_CTRL, st = `SCS_ADDR_STAT;
  localparam logic [2:0] tx = `SCS_ADDR_TXD, rx = `SCS_ADDR_RXD, cd = `SCS_ADDR_CARD;
  logic       clk, sys_rst, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  scs_line_s  line_in;
  scs_ctl_s   ctl_out;
  int         err_count, n_compared, cnt;
  scs_core DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in), .ctl_out(ctl_out));
  scs_line_model u_line (.clk(clk), .line_in(line_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge clk);
  endtask
  initial begin
    #500000;
    err_count++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(st, 8'h84);
    rd(ct, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wr(st, 8'hFE);
    rd(st, 8'h84);
    wr(ct, 8'h84);
    wr(st, 8'h00);
    rd(st, 8'h84);
    `CHK(ctl_out.tx_done_irq, 1'b1)
    wr(tx, 8'h5A);
    wr(ct, 8'hA4);
    rd(st, 8'h84);
    wr(st, 8'h00);
    repeat (3) @(posedge clk);
    rd(st, 8'h80);
    `CHK(ctl_out.tx_empty_irq, 1'b1)
    u_line.strobe('{tx_last_bit: 1'b1, default: '0});
    rd(st, 8'h84);
    `CHK(ctl_out.tx_done_irq, 1'b1)
    u_line.strobe('{dma_tx_ack: 1'b1, default: '0});
    repeat (3) @(posedge clk);
    rd(st, 8'h80);
    `CHK(ctl_out.tx_done_irq, 1'b0)
    wr(ct, 8'h40);
    u_line.frame(8'h77, 1'b0, 1'b0, 1'b0);
    rd(st, 8'h84);
    wr(ct, 8'h50);
    u_line.frame(8'hC3, 1'b0, 1'b0, 1'b0);
    rd(st, 8'hC4);
    `CHK(ctl_out.rx_full_irq, 1'b1)
    u_line.frame(8'h3C, 1'b0, 1'b0, 1'b0);
    rd(st, 8'hE4);
    rd(rx, 8'hC3);
    wr(ct, 8'h40);
    rd(st, 8'hE4);
    `CHK(ctl_out.rx_err_irq, 1'b1)
    wr(st, 8'h00);
    rd(st, 8'h84);
    wr(ct, 8'h50);
    u_line.frame(8'h11, 1'b0, 1'b1, 1'b0);
    rd(st, 8'h94);
    u_line.frame(8'h22, 1'b0, 1'b0, 1'b0);
    rd(st, 8'h94);
    wr(st, 8'h00);
    u_line.frame(8'h33, 1'b0, 1'b0, 1'b1);
    rd(st, 8'h8C);
    wr(st, 8'h00);
    wr(md, 8'h04);
    wr(ct, 8'h58);
    u_line.frame(8'hAA, 1'b0, 1'b0, 1'b0);
    rd(st, 8'h84);
    rd(ct, 8'h58);
    u_line.frame(8'h55, 1'b1, 1'b0, 1'b0);
    rd(st, 8'hC6);
    rd(ct, 8'h50);
    rd(rx, 8'h55);
    u_line.strobe('{dma_rx_ack: 1'b1, default: '0});
    rd(st, 8'h86);
    for (int i = 0; i < 4; i++) begin
      wr(md, 8'(i));
      repeat (140) @(posedge clk);
      cnt = 0;
      repeat (128) begin
        @(negedge clk);
        cnt += int'(ctl_out.baud_tick === 1'b1);
      end
      `CHK(cnt, 128 >> (2 * i))
      @(posedge clk);
    end
    for (int m = 0; m < 4; m++) begin
      wr(cd, {7'h00, m[1]});
      for (int c = 0; c < 4; c++) begin
        wr(ct, 8'(c));
        wr(md, {m[0], 7'h00});
        repeat (3) @(posedge clk);
      end
    end
    complete_run();
  end
endmodule
bind scs_core scs_core_sva u_sva (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .ctl_out(ctl_out));
`default_nettype wire
